/* rtl/mfsf_defs.vh */
// Register offsets, field positions and reset values of the fault status flags
`ifndef MFSF_DEFS_VH
`define MFSF_DEFS_VH
`define MFSF_ADDR_PRIMARY 8'h41
`define MFSF_ADDR_SECONDARY 8'h42
`define MFSF_RESET_VALUE 8'h00
// Primary register fields
`define MFSF_P_V25 0
`define MFSF_P_CORE 1
`define MFSF_P_V33 2
`define MFSF_P_V50 3
`define MFSF_P_DIODE_A_ANODE_ZONE 4
`define MFSF_P_INTERNAL_ZONE 5
`define MFSF_P_DIODE_B_ANODE_ZONE 6
`define MFSF_P_SUMMARY 7
// Secondary register fields
`define MFSF_S_V12 0
`define MFSF_S_RESERVED 1
`define MFSF_S_FAN_LSB 2
`define MFSF_S_DIODE1 6
`define MFSF_S_DIODE2 7
`endif

/* rtl/mfsf_status.v */
// Sticky fault status flag registers of the hardware monitor
`include "mfsf_defs.vh"
`default_nettype none

module mfsf_status (
   input wire ref_clk,
   input wire arst_n,
   // Register access port: one-cycle strobes, address of the current access
   input wire [7:0] reg_addr,
   input wire reg_rd,
   input wire reg_wr,
   input wire [7:0] reg_wdata,
   output reg [7:0] reg_rdata,
   output wire reg_hit,
   // Supply readings and limits, unsigned
   input wire [7:0] v25_reading,
   input wire [7:0] v25_low,
   input wire [7:0] v25_high,
   input wire [7:0] core_supply_input,
   input wire [7:0] core_low,
   input wire [7:0] core_high,
   input wire [7:0] v33_reading,
   input wire [7:0] v33_low,
   input wire [7:0] v33_high,
   input wire [7:0] v50_reading,
   input wire [7:0] v50_low,
   input wire [7:0] v50_high,
   input wire [7:0] v12_reading,
   input wire [7:0] v12_low,
   input wire [7:0] v12_high,
   // Temperature readings and limits, two's complement
   input wire [7:0] diode_a_anode_temp,
   input wire [7:0] zone1_low,
   input wire [7:0] zone1_high,
   input wire [7:0] internal_temp,
   input wire [7:0] zone2_low,
   input wire [7:0] zone2_high,
   input wire [7:0] diode_b_anode_temp,
   input wire [7:0] zone3_low,
   input wire [7:0] zone3_high,
   // Remote diode open or short indications
   input wire diode_a_fault,
   input wire diode_b_fault,
   // Tachometer period counts and minimum limits, fans a..d packed low to high
   input wire [63:0] fan_period,
   input wire [63:0] fan_minimum,
   // Latched flags, for the rest of the monitor
   output wire [7:0] status_primary,
   output wire [7:0] status_secondary
);

   // ---------------------------------------------------------------
   // Fault conditions
   // ---------------------------------------------------------------
   wire [7:0] cond_p;
   wire [7:0] cond_s;
   wire [3:0] fan_stall;
   reg [7:0] prim_q;
   reg [7:0] prim_d;
   reg [7:0] sec_q;
   reg [7:0] sec_d;
   wire rd_prim;
   wire rd_sec;
   wire diode_a_anode_out;
   wire diode_b_anode_out;

   // Supplies: low limit inclusive on the four primary inputs
   mfsf_window #(
      .IS_SIGNED(0),
      .LOW_INCLUSIVE(1)
   ) i_v25_win (
      .value(v25_reading),
      .low(v25_low),
      .high(v25_high),
      .outside(cond_p[`MFSF_P_V25])
   );
   mfsf_window #(
      .IS_SIGNED(0),
      .LOW_INCLUSIVE(1)
   ) i_core_win (
      .value(core_supply_input),
      .low(core_low),
      .high(core_high),
      .outside(cond_p[`MFSF_P_CORE])
   );
   mfsf_window #(
      .IS_SIGNED(0),
      .LOW_INCLUSIVE(1)
   ) i_v33_win (
      .value(v33_reading),
      .low(v33_low),
      .high(v33_high),
      .outside(cond_p[`MFSF_P_V33])
   );
   mfsf_window #(
      .IS_SIGNED(0),
      .LOW_INCLUSIVE(1)
   ) i_v50_win (
      .value(v50_reading),
      .low(v50_low),
      .high(v50_high),
      .outside(cond_p[`MFSF_P_V50])
   );

   // Temperatures: signed, low limit inclusive
   mfsf_window #(
      .IS_SIGNED(1),
      .LOW_INCLUSIVE(1)
   ) i_diode_a_anode_win (
      .value(diode_a_anode_temp),
      .low(zone1_low),
      .high(zone1_high),
      .outside(diode_a_anode_out)
   );
   assign cond_p[`MFSF_P_DIODE_A_ANODE_ZONE] = diode_a_anode_out || diode_a_fault;
   mfsf_window #(
      .IS_SIGNED(1),
      .LOW_INCLUSIVE(1)
   ) i_internal_win (
      .value(internal_temp),
      .low(zone2_low),
      .high(zone2_high),
      .outside(cond_p[`MFSF_P_INTERNAL_ZONE])
   );
   // Zone 3 compares against its own low limit
   mfsf_window #(
      .IS_SIGNED(1),
      .LOW_INCLUSIVE(1)
   ) i_diode_b_anode_win (
      .value(diode_b_anode_temp),
      .low(zone3_low),
      .high(zone3_high),
      .outside(diode_b_anode_out)
   );
   assign cond_p[`MFSF_P_DIODE_B_ANODE_ZONE] = diode_b_anode_out || diode_b_fault;
   assign cond_p[`MFSF_P_SUMMARY] = 1'b0;

   // The 12V check is strict on both sides, unlike the other supplies
   mfsf_window #(
      .IS_SIGNED(0),
      .LOW_INCLUSIVE(0)
   ) i_v12_win (
      .value(v12_reading),
      .low(v12_low),
      .high(v12_high),
      .outside(cond_s[`MFSF_S_V12])
   );
   assign cond_s[`MFSF_S_RESERVED] = 1'b0;

   genvar i;
   generate
      for (i = 0; i < 4; i = i + 1)
      begin : g_fan
         // A slow fan gives a long period, so larger than minimum means stalled
         assign fan_stall[i] = fan_period[16*i +: 16] > fan_minimum[16*i +: 16];
      end
   endgenerate
   assign cond_s[`MFSF_S_FAN_LSB +: 4] = fan_stall;
   assign cond_s[`MFSF_S_DIODE1] = diode_a_fault;
   assign cond_s[`MFSF_S_DIODE2] = diode_b_fault;

   // ---------------------------------------------------------------
   // Sticky flags
   // ---------------------------------------------------------------
   assign rd_prim = reg_rd && (reg_addr == `MFSF_ADDR_PRIMARY);
   assign rd_sec = reg_rd && (reg_addr == `MFSF_ADDR_SECONDARY);

   always @*
   begin
      // Clearing keeps any flag whose condition is still present this cycle
      prim_d = prim_q | cond_p;
      if (rd_prim)
      begin
         prim_d = cond_p;
      end
      sec_d = sec_q | cond_s;
      if (rd_sec)
      begin
         sec_d = cond_s;
      end
      prim_d[`MFSF_P_SUMMARY] = 1'b0;
      sec_d[`MFSF_S_RESERVED] = 1'b0;
   end

   // Writes never reach the flags
   always @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         prim_q <= `MFSF_RESET_VALUE;
         sec_q <= `MFSF_RESET_VALUE;
      end
      else
      begin
         prim_q <= prim_d;
         sec_q <= sec_d;
      end
   end

   // Summary follows the latched secondary register, so it drops as that clears
   assign status_primary = {(|sec_q), prim_q[6:0]};
   assign status_secondary = sec_q;

   // ---------------------------------------------------------------
   // Read data
   // ---------------------------------------------------------------
   assign reg_hit = (reg_addr == `MFSF_ADDR_PRIMARY) || (reg_addr == `MFSF_ADDR_SECONDARY);

   // Data is captured from the flags before the clear takes effect
   always @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         reg_rdata <= `MFSF_RESET_VALUE;
      end
      else if (rd_prim)
      begin
         reg_rdata <= status_primary;
      end
      else if (rd_sec)
      begin
         reg_rdata <= status_secondary;
      end
      else if (reg_rd)
      begin
         reg_rdata <= 8'h00;
      end
   end

endmodule

// ---------------------------------------------------------------
// Window comparator
// ---------------------------------------------------------------
// One limit check; the low bound is inclusive or strict, the order signed or not
module mfsf_window #(
   parameter IS_SIGNED = 0,
   parameter LOW_INCLUSIVE = 1
) (
   input wire [7:0] value,
   input wire [7:0] low,
   input wire [7:0] high,
   output wire outside
);

   wire [7:0] sign_flip;
   wire [7:0] value_cmp;
   wire [7:0] low_cmp;
   wire [7:0] high_cmp;
   wire below_low;
   wire above_high;

   // Inverting the sign bit maps two's complement order onto unsigned order
   assign sign_flip = (IS_SIGNED != 0) ? 8'h80 : 8'h00;
   assign value_cmp = value ^ sign_flip;
   assign low_cmp = low ^ sign_flip;
   assign high_cmp = high ^ sign_flip;
   assign below_low = (LOW_INCLUSIVE != 0) ? (value_cmp <= low_cmp) : (value_cmp < low_cmp);
   assign above_high = value_cmp > high_cmp;
   assign outside = below_low || above_high;

endmodule

`default_nettype wire

/* dv/mfsf_status_assertions.sv */
// Port assertions for the fault status flags
`default_nettype none
module mfsf_status_assertions (
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic reg_rd,
   input wire logic diode_a_fault,
   input wire logic diode_b_fault,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_rdata,
   input wire logic [7:0] v12_reading,
   input wire logic [7:0] v12_low,
   input wire logic [7:0] internal_temp,
   input wire logic [7:0] zone2_high,
   input wire logic [7:0] status_primary,
   input wire logic [7:0] status_secondary,
   input wire logic [63:0] fan_period,
   input wire logic [63:0] fan_minimum
);
   timeunit 1ns;
   timeprecision 1ps;
   // ------
   // Checks
   // ------
   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (!arst_n);
   summary_bit_a: assert property (status_primary[7] == |status_secondary)
      else $error("summary bit wrong");
   reserved_zero_a: assert property (!status_secondary[1])
      else $error("reserved bit set");
   v12_low_a: assert property (v12_reading < v12_low |=> status_secondary[0])
      else $error("12V flag missed");
   temp_sign_a: assert property ($signed(internal_temp) > $signed(zone2_high)
      |=> status_primary[5]) else $error("die zone flag missed");
   fan_stall_a: assert property (fan_period[15:0] > fan_minimum[15:0]
      |=> status_secondary[2]) else $error("fan flag missed");
   diode_one_a: assert property (diode_a_fault
      |=> status_secondary[6] && status_primary[4]) else $error("diode 1 flags missed");
   diode_two_a: assert property (diode_b_fault
      |=> status_secondary[7] && status_primary[6]) else $error("diode 2 flags missed");
   sticky_flag_a: assert property (status_secondary[0] && !reg_rd
      |=> status_secondary[0]) else $error("flag lost without read");
   read_data_a: assert property (reg_rd && reg_addr == 8'h42
      |=> reg_rdata == $past(status_secondary)) else $error("read data wrong");
   read_clear_a: assert property (reg_rd && reg_addr == 8'h42 && !diode_a_fault
      |=> !status_secondary[6]) else $error("diode 1 flag not cleared by read");
endmodule
bind mfsf_status mfsf_status_assertions i_chk (.ref_clk, .arst_n, .reg_rd, .diode_a_fault,
   .diode_b_fault, .reg_addr, .reg_rdata, .v12_reading, .v12_low, .internal_temp,
   .zone2_high, .status_primary, .status_secondary, .fan_period, .fan_minimum);
`default_nettype wire

/* dv/mfsf_host.sv */
// Host model issuing status register reads
`default_nettype none
module mfsf_host (
   input wire logic ref_clk,
   output logic reg_rd = 1'b0,
   output logic [7:0] reg_addr = 8'h00
);
   timeunit 1ns;
   timeprecision 1ps;
   task automatic read(input logic [7:0] a);
      @(negedge ref_clk);
      reg_rd = 1'b1;
      reg_addr = a;
      @(negedge ref_clk);
      reg_rd = 1'b0;
      // Released address changes so a stale value is never relied on
      reg_addr = ~a;
   endtask
endmodule
`default_nettype wire

/* dv/mfsf_status_tb_top.sv */
// Testbench of the fault status flags
`default_nettype none
module mfsf_status_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 1'b0, arst_n = 1'b0, reg_wr, diode_a_fault, diode_b_fault, reg_rd;
   logic [7:0] reg_addr, reg_wdata, r [8], l [8], h [8], exp_q [$];
   logic [63:0] fan_period, fan_minimum;
   logic [15:0] lat = 16'h0000, c;
   wire [7:0] reg_rdata, status_primary, status_secondary;
   wire reg_hit;
   int failures = 0, n_checks = 0, seed = 48757;
   always #5 ref_clk = ~ref_clk;
   mfsf_host i_host (.ref_clk, .reg_rd, .reg_addr);
   mfsf_status i_dut (.v25_reading(r[0]), .v25_low(l[0]), .v25_high(h[0]),
      .core_supply_input(r[1]), .core_low(l[1]), .core_high(h[1]),
      .v33_reading(r[2]), .v33_low(l[2]), .v33_high(h[2]),
      .v50_reading(r[3]), .v50_low(l[3]), .v50_high(h[3]),
      .diode_a_anode_temp(r[4]), .zone1_low(l[4]), .zone1_high(h[4]),
      .internal_temp(r[5]), .zone2_low(l[5]), .zone2_high(h[5]),
      .diode_b_anode_temp(r[6]), .zone3_low(l[6]), .zone3_high(h[6]),
      .v12_reading(r[7]), .v12_low(l[7]), .v12_high(h[7]),
      .ref_clk, .arst_n, .reg_addr, .reg_rd, .reg_wr, .reg_wdata, .reg_rdata, .reg_hit,
      .diode_a_fault, .diode_b_fault, .fan_period, .fan_minimum,
      .status_primary, .status_secondary);
   // ---------------
   // Reference model
   // ---------------
   function automatic logic [15:0] cond();
      logic [7:0] k;
      logic [3:0] f;
      for (int j = 0; j < 8; j++)
         k[j] = (j > 3 && j < 7) ? ($signed(r[j]) <= $signed(l[j])
            || $signed(r[j]) > $signed(h[j])) : (r[j] < l[j] || r[j] == l[j] && j < 4
            || r[j] > h[j]);
      for (int j = 0; j < 4; j++)
         f[j] = fan_period[16*j+:16] > fan_minimum[16*j+:16];
      return {diode_b_fault, diode_a_fault, f, 1'b0, k[7], 1'b0,
         k[6] | diode_b_fault, k[5], k[4] | diode_a_fault, k[3:0]};
   endfunction
   // Quiet sets clear every condition so read-clears are really seen
   task automatic setin(input bit q);
      for (int j = 0; j < 8; j++)
      begin
         r[j] = q ? 8'h10 : 8'($random(seed));
         l[j] = q ? 8'h00 : 8'($random(seed));
         h[j] = q ? 8'h7f : 8'($random(seed));
      end
      fan_period = q ? 64'h0 : {$random(seed), $random(seed)};
      fan_minimum = q ? '1 : {$random(seed), $random(seed)};
      {diode_a_fault, diode_b_fault} = q ? 2'b00 : 2'($random(seed));
      {reg_wr, reg_wdata} = 9'($random(seed));
      lat = lat | cond();
   endtask
   task automatic rd(input logic [7:0] a, e);
      exp_q.push_back(e);
      i_host.read(a);
   endtask
   task automatic check(input string nm, input logic [7:0] s, e);
      n_checks++;
      if (s !== e)
      begin
         failures++;
         $display("CHECK FAILED %s exp %h seen %h", nm, e, s);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   always @(posedge ref_clk)
      if (reg_rd === 1'b1)
      begin
         #1;
         check("reg_rdata", reg_rdata, exp_q.pop_front());
         check("reg_hit", 8'(reg_hit), 8'(reg_addr == 8'h41 || reg_addr == 8'h42));
      end
   initial
   begin
      setin(1'b1);
      repeat (5) @(negedge ref_clk);
      arst_n = 1'b1;
      check("status_primary", status_primary, 8'h00);
      check("status_secondary", status_secondary, 8'h00);
      $display("test reset done");
      for (int n = 0; n < 60; n++)
      begin
         @(negedge ref_clk);
         setin(1'($random(seed)));
         rd(8'h41, {|lat[15:8], lat[6:0]});
         c = cond();
         lat[7:0] = c[7:0];
         rd(8'h42, lat[15:8]);
         lat[15:8] = c[15:8];
         rd(8'h43, 8'h00);
      end
      repeat (2) @(negedge ref_clk);
      $display("test random done");
      // Mid-run reset drops every flag and the read data at once
      @(negedge ref_clk);
      arst_n = 1'b0;
      setin(1'b1);
      lat = 16'h0000;
      #1;
      check("status_primary", status_primary, 8'h00);
      check("status_secondary", status_secondary, 8'h00);
      check("reg_rdata", reg_rdata, 8'h00);
      repeat (2) @(negedge ref_clk);
      arst_n = 1'b1;
      rd(8'h41, 8'h00);
      rd(8'h42, 8'h00);
      repeat (2) @(negedge ref_clk);
      $display("test second reset done");
      stop_test();
   end
   initial
   begin
      #50000;
      failures++;
      stop_test();
   end
endmodule
`default_nettype wire
